//--- core/ppr_duty_pair.sv
// one 16-bit duty register pair with low-first write staging and high-first read snapshot
`timescale 1ns/1ps
module ppr_duty_pair #(
	parameter int WIDTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire ppr_pkg::ppr_byte_req_t req,
	output logic [7:0] rdata,
	output logic [WIDTH-1:0] duty,
	output logic update
);
	typedef struct packed {
		ppr_pkg::ppr_duty_t pair;
		logic upd;
	} ppr_pair_state_t;

	ppr_pair_state_t s_q;
	ppr_pair_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.upd = 1'b0;
		if (req.wr && req.sel_low) begin
			// low byte only waits in staging; live value is untouched
			s_d.pair.wr_low_stage = req.wdata;
		end
		if (req.wr && req.sel_high) begin
			// high write commits both bytes as one update
			s_d.pair.value = {req.wdata, s_q.pair.wr_low_stage};
			s_d.upd = 1'b1;
		end
		if (req.rd && req.sel_high) begin
			s_d.pair.rd_low_snap = s_q.pair.value[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{pair: '{wr_low_stage: ppr_pkg::RST_DUTY_BYTE,
				value: {ppr_pkg::RST_DUTY_BYTE, ppr_pkg::RST_DUTY_BYTE},
				rd_low_snap: ppr_pkg::RST_DUTY_BYTE}, upd: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// low reads return the snapshot taken at the last high read
	always_comb begin
		rdata = 8'h00;
		if (req.sel_high) begin
			rdata = s_q.pair.value[15:8];
		end else if (req.sel_low) begin
			rdata = s_q.pair.rd_low_snap;
		end
	end

	assign duty = s_q.pair.value;
	assign update = s_q.upd;
endmodule

//--- core/ppr_pkg.sv
// package: offsets, reset values and carriers for the pwm period/duty register front end
package ppr_pkg;
	// register indices; the apb byte address is four times the index
	localparam logic [7:0] IDX_CHAN0_PERIOD_LOW = 8'hDA;
	localparam logic [7:0] IDX_GROUP_PERIOD_HIGH = 8'hDB;
	localparam logic [7:0] IDX_GROUP_PERIOD_LOW = 8'hDC;
	localparam logic [7:0] IDX_CHAN3_DUTY_HIGH = 8'hDD;
	localparam logic [7:0] IDX_CHAN3_DUTY_LOW = 8'hDE;
	localparam logic [7:0] IDX_CHAN4_DUTY_HIGH = 8'hE9;
	localparam logic [7:0] IDX_CHAN4_DUTY_LOW = 8'hEA;
	localparam logic [7:0] IDX_CHAN5_DUTY_HIGH = 8'hEB;
	localparam logic [7:0] IDX_CHAN5_DUTY_LOW = 8'hEC;
	localparam logic [7:0] IDX_CHAN6_DUTY_HIGH = 8'hED;
	localparam logic [7:0] IDX_CHAN6_DUTY_LOW = 8'hEE;
	localparam logic [7:0] IDX_AUXILIARY_CONTROL = 8'hF8;

	// apb address width: eight index bits above two byte bits
	localparam int ADDR_W = 10;

	// auxiliary_control field positions
	localparam int AUX_FIRST_CLEAR_BIT = 3;
	localparam int AUX_GROUP_CLEAR_BIT = 2;

	// reset values
	localparam logic [7:0] RST_PERIOD_BYTE = 8'hFF;
	localparam logic [7:0] RST_DUTY_BYTE = 8'h00;
	localparam logic [7:0] RST_AUX = 8'h0C;
	localparam logic [7:0] AUX_IMPL_MASK = 8'h0C;

	// number of duty channels in this front end (channels 3 to 6)
	localparam int NUM_DUTY = 4;

	// one 16-bit duty pair: byte staging and read snapshot
	typedef struct packed {
		logic [7:0] wr_low_stage;
		logic [15:0] value;
		logic [7:0] rd_low_snap;
	} ppr_duty_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic sel_high;
		logic sel_low;
		logic [7:0] wdata;
	} ppr_byte_req_t;
endpackage

//--- core/ppr_regs.sv
// apb register front end for pwm period, duty and clear-and-hold controls
// Notes on behaviour
// - duty write: low first, high commits both
// - duty read: high first captures low byte
// - duty bytes are read/write, reset zero
// - aux bit 2 clears and holds channels 1-6
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module ppr_regs #(
	parameter int NUM_DUTY = ppr_pkg::NUM_DUTY
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ppr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] chan0_period_low,
	output logic [15:0] group_period,
	output logic [16*NUM_DUTY-1:0] duty_values,
	output logic [NUM_DUTY-1:0] duty_update,
	output logic first_channel_clear_hold,
	output logic group_clear_hold
);
	typedef struct packed {
		logic [7:0] chan0_period_low;
		logic [7:0] group_period_high;
		logic [7:0] group_period_low;
		logic [7:0] auxiliary_control;
	} ppr_state_t;

	ppr_state_t s_q;
	ppr_state_t s_d;

	logic [7:0] idx;
	logic hit_regular;
	logic hit_any;
	logic access;
	logic wr_acc;
	logic rd_acc;
	logic [7:0] duty_rdata [NUM_DUTY];
	logic [7:0] duty_high_idx [NUM_DUTY];
	logic [7:0] duty_low_idx [NUM_DUTY];
	logic [NUM_DUTY-1:0] duty_hit;

	// registers answer in the access phase with no wait states
	assign access = psel && penable;
	assign idx = paddr[ppr_pkg::ADDR_W-1:2];
	assign wr_acc = access && pwrite && pstrb[0];
	assign rd_acc = access && !pwrite;

	assign duty_high_idx[0] = ppr_pkg::IDX_CHAN3_DUTY_HIGH;
	assign duty_low_idx[0] = ppr_pkg::IDX_CHAN3_DUTY_LOW;
	assign duty_high_idx[1] = ppr_pkg::IDX_CHAN4_DUTY_HIGH;
	assign duty_low_idx[1] = ppr_pkg::IDX_CHAN4_DUTY_LOW;
	assign duty_high_idx[2] = ppr_pkg::IDX_CHAN5_DUTY_HIGH;
	assign duty_low_idx[2] = ppr_pkg::IDX_CHAN5_DUTY_LOW;
	assign duty_high_idx[3] = ppr_pkg::IDX_CHAN6_DUTY_HIGH;
	assign duty_low_idx[3] = ppr_pkg::IDX_CHAN6_DUTY_LOW;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DUTY; gi++) begin : g_duty
			ppr_pkg::ppr_byte_req_t req;
			always_comb begin
				req.wr = wr_acc;
				req.rd = rd_acc;
				req.sel_high = (idx == duty_high_idx[gi]) && (paddr[1:0] == 2'h0);
				req.sel_low = (idx == duty_low_idx[gi]) && (paddr[1:0] == 2'h0);
				req.wdata = pwdata[7:0];
			end
			assign duty_hit[gi] = req.sel_high || req.sel_low;
			ppr_duty_pair #(
				.WIDTH(16)
			) u_pair (
				.pclk(pclk),
				.presetn(presetn),
				.req(req),
				.rdata(duty_rdata[gi]),
				.duty(duty_values[16*gi +: 16]),
				.update(duty_update[gi])
			);
		end
	endgenerate

	always_comb begin
		hit_regular = 1'b1;
		if (paddr[1:0] != 2'h0) begin
			hit_regular = 1'b0;
		end else begin
			unique case (idx)
				ppr_pkg::IDX_CHAN0_PERIOD_LOW,
				ppr_pkg::IDX_GROUP_PERIOD_HIGH,
				ppr_pkg::IDX_GROUP_PERIOD_LOW,
				ppr_pkg::IDX_AUXILIARY_CONTROL: hit_regular = 1'b1;
				default: hit_regular = 1'b0;
			endcase
		end
		hit_any = hit_regular || (|duty_hit);
	end

	always_comb begin
		s_d = s_q;
		if (wr_acc && hit_regular) begin
			unique case (idx)
				ppr_pkg::IDX_CHAN0_PERIOD_LOW: s_d.chan0_period_low = pwdata[7:0];
				ppr_pkg::IDX_GROUP_PERIOD_HIGH: s_d.group_period_high = pwdata[7:0];
				ppr_pkg::IDX_GROUP_PERIOD_LOW: s_d.group_period_low = pwdata[7:0];
				// only the two clear controls live here; other aux bits read zero
				ppr_pkg::IDX_AUXILIARY_CONTROL:
					s_d.auxiliary_control = pwdata[7:0] & ppr_pkg::AUX_IMPL_MASK;
				default: s_d = s_q;
			endcase
		end
	end

	// read data is combinational in the access phase so pready can stay high
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_acc) begin
			if (hit_regular) begin
				unique case (idx)
					ppr_pkg::IDX_CHAN0_PERIOD_LOW: prdata[7:0] = s_q.chan0_period_low;
					ppr_pkg::IDX_GROUP_PERIOD_HIGH: prdata[7:0] = s_q.group_period_high;
					ppr_pkg::IDX_GROUP_PERIOD_LOW: prdata[7:0] = s_q.group_period_low;
					ppr_pkg::IDX_AUXILIARY_CONTROL: prdata[7:0] = s_q.auxiliary_control;
					default: prdata = 32'h0000_0000;
				endcase
			end else begin
				for (int i = 0; i < NUM_DUTY; i++) begin
					if (duty_hit[i]) begin
						prdata[7:0] = duty_rdata[i];
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{chan0_period_low: ppr_pkg::RST_PERIOD_BYTE,
				group_period_high: ppr_pkg::RST_PERIOD_BYTE,
				group_period_low: ppr_pkg::RST_PERIOD_BYTE,
				auxiliary_control: ppr_pkg::RST_AUX};
		end else begin
			s_q <= s_d;
		end
	end

	assign pready = 1'b1;
	// unmapped or misaligned addresses answer with an error and have no effect
	assign pslverr = access && !hit_any;

	assign chan0_period_low = s_q.chan0_period_low;
	assign group_period = {s_q.group_period_high, s_q.group_period_low};
	// channels stay cleared while their hold bit is set
	assign first_channel_clear_hold = s_q.auxiliary_control[ppr_pkg::AUX_FIRST_CLEAR_BIT];
	assign group_clear_hold = s_q.auxiliary_control[ppr_pkg::AUX_GROUP_CLEAR_BIT];
endmodule

//--- verification/ppr_regs_chk.sv
// checker: concurrent assertions on the pwm register front end ports
`timescale 1ns/1ps
module ppr_regs_chk #(
	parameter int NUM_DUTY = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic [15:0] group_period,
	input wire logic [16*NUM_DUTY-1:0] duty_values,
	input wire logic [NUM_DUTY-1:0] duty_update,
	input wire logic first_channel_clear_hold,
	input wire logic group_clear_hold
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic wr = psel && penable && pwrite && pstrb[0];
	sequence s_hi_wr;
		wr && paddr == {ppr_pkg::IDX_CHAN3_DUTY_HIGH, 2'b00};
	endsequence
	sequence s_commit;
		duty_update[0] && duty_values[15:8] == $past(pwdata[7:0]);
	endsequence
	a_high_commits: assert property (s_hi_wr |=> s_commit)
		else $error("chan3 high write did not commit");
	a_update_single: assert property (duty_update[0] |=> !duty_update[0])
		else $error("duty update longer than one cycle");
	a_change_needs_update: assert property ($changed(duty_values[15:0]) |-> duty_update[0])
		else $error("chan3 duty changed without update");
	a_low_no_commit: assert property (wr && paddr == {ppr_pkg::IDX_CHAN3_DUTY_LOW, 2'b00}
		|=> $stable(duty_values)) else $error("low byte write changed duty");
	a_group_hold: assert property (wr && paddr == {ppr_pkg::IDX_AUXILIARY_CONTROL, 2'b00}
		|=> group_clear_hold == $past(pwdata[2])) else $error("group hold not written");
	a_first_hold: assert property (wr && paddr == {ppr_pkg::IDX_AUXILIARY_CONTROL, 2'b00}
		|=> first_channel_clear_hold == $past(pwdata[3])) else $error("first hold not written");
	a_read_pad: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_reset_values: assert property ($rose(presetn) |-> group_period == 16'hFFFF
		&& first_channel_clear_hold && group_clear_hold) else $error("bad reset values");
endmodule
bind ppr_regs ppr_regs_chk #(.NUM_DUTY(NUM_DUTY)) ppr_regs_chk_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .group_period(group_period),
	.duty_values(duty_values), .duty_update(duty_update), .group_clear_hold(group_clear_hold),
	.first_channel_clear_hold(first_channel_clear_hold));

//--- verification/ppr_regs_test.sv
// testbench: apb register sequences against the pwm register front end
`timescale 1ns/1ps
module ppr_regs_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, fch, gch;
	logic [9:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic [3:0] pstrb = 4'hF, du;
	logic [7:0] c0p;
	logic [15:0] gp;
	logic [63:0] dv;
	logic e;
	int err_total = 0, samples_checked = 0;
	localparam logic [7:0] HI [4] = '{ppr_pkg::IDX_CHAN3_DUTY_HIGH, ppr_pkg::IDX_CHAN4_DUTY_HIGH,
		ppr_pkg::IDX_CHAN5_DUTY_HIGH, ppr_pkg::IDX_CHAN6_DUTY_HIGH};
	localparam logic [7:0] LO [4] = '{ppr_pkg::IDX_CHAN3_DUTY_LOW, ppr_pkg::IDX_CHAN4_DUTY_LOW,
		ppr_pkg::IDX_CHAN5_DUTY_LOW, ppr_pkg::IDX_CHAN6_DUTY_LOW};
	localparam logic [7:0] AUX = ppr_pkg::IDX_AUXILIARY_CONTROL;
	always #10 pclk = ~pclk;
	ppr_regs ppr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chan0_period_low(c0p), .group_period(gp),
		.duty_values(dv), .duty_update(du), .first_channel_clear_hold(fch),
		.group_clear_hold(gch));
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one apb transfer; the answer is taken at the edge that sees pready high
	task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			final_report();
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		xfer(idx, 1'b0, 8'h00);
		check("read data", q, {24'h0, exp});
		check("read slave error", {31'h0, e}, 32'h0);
	endtask
	initial begin
		logic [7:0] b;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		check("holds", {30'h0, fch, gch}, 32'h3);
		check("group period", {16'h0, gp}, 32'hFFFF);
		rd(ppr_pkg::IDX_CHAN0_PERIOD_LOW, 8'hFF);
		rd(ppr_pkg::IDX_GROUP_PERIOD_HIGH, 8'hFF);
		rd(AUX, 8'h0C);
		for (int i = 0; i < 4; i++) begin
			b = 8'(i);
			rd(HI[i], 8'h00);
			rd(LO[i], 8'h00);
			xfer(LO[i], 1'b1, 8'h10 + b);
			check("duty staged", {16'h0, dv[16*i+:16]}, 32'h0);
			check("update after low", {28'h0, du}, 32'h0);
			xfer(HI[i], 1'b1, 8'hA0 + b);
			check("update after high", {28'h0, du}, 32'h1 << i);
			check("duty", {16'h0, dv[16*i+:16]}, {16'h0, 8'hA0 + b, 8'h10 + b});
			rd(HI[i], 8'hA0 + b);
			rd(LO[i], 8'h10 + b);
		end
		// a staged low byte must not leak into the read snapshot
		xfer(LO[0], 1'b1, 8'h77);
		rd(HI[0], 8'hA0);
		rd(LO[0], 8'h10);
		xfer(HI[0], 1'b1, 8'h5C);
		check("duty", {16'h0, dv[15:0]}, 32'h5C77);
		// low reads keep returning the snapshot until the next high read
		rd(HI[0], 8'h5C);
		xfer(LO[0], 1'b1, 8'h11);
		xfer(HI[0], 1'b1, 8'h22);
		rd(LO[0], 8'h77);
		rd(HI[0], 8'h22);
		rd(LO[0], 8'h11);
		for (int k = 0; k < 4; k++) begin
			b = {4'h0, 2'(k), 2'b00};
			xfer(AUX, 1'b1, b | 8'hF3);
			check("holds", {30'h0, fch, gch}, {30'h0, b[3:2]});
			rd(AUX, b);
		end
		xfer(ppr_pkg::IDX_GROUP_PERIOD_HIGH, 1'b1, 8'h12);
		xfer(ppr_pkg::IDX_GROUP_PERIOD_LOW, 1'b1, 8'h34);
		check("group period", {16'h0, gp}, 32'h1234);
		rd(ppr_pkg::IDX_GROUP_PERIOD_LOW, 8'h34);
		xfer(ppr_pkg::IDX_CHAN0_PERIOD_LOW, 1'b1, 8'h5A);
		check("chan0 period", {24'h0, c0p}, 32'h5A);
		rd(ppr_pkg::IDX_CHAN0_PERIOD_LOW, 8'h5A);
		// a write with byte lane 0 off must store nothing and raise no error
		pstrb <= 4'hE;
		xfer(ppr_pkg::IDX_GROUP_PERIOD_LOW, 1'b1, 8'h99);
		pstrb <= 4'hF;
		check("masked write", {16'h0, gp}, 32'h1234);
		check("masked slave error", {31'h0, e}, 32'h0);
		// a second reset in mid-run must bring back every reset value
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		check("duty after reset", dv[31:0], 32'h0);
		check("duty after reset", dv[63:32], 32'h0);
		check("holds after reset", {30'h0, fch, gch}, 32'h3);
		check("period after reset", {8'h0, gp, c0p}, 32'h00FF_FFFF);
		rd(LO[3], 8'h00);
		xfer(8'hE0, 1'b0, 8'h00);
		check("slave error", {31'h0, e}, 32'h1);
		final_report();
	end
endmodule
